/* File: hw/relay_timing.sv */
module relay_timing
	import relay_timing_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic clk_en_i,
	input wire logic supply_ok_i,
	input wire logic trigger_sw_i,
	input wire logic [1:0] func_sel_i,
	input wire logic [DELAY_W-1:0] delay_cycles_i,
	output logic relay_o,
	output logic timing_o
);

	// ==========================================================
	// Trigger conditioning
	logic trig_level;
	logic trig_close;
	logic trig_open;

	switch_debounce u_deb (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.clk_en_i(clk_en_i),
		.raw_i(trigger_sw_i),
		.level_o(trig_level),
		.rise_o(trig_close),
		.fall_o(trig_open)
	);

	// ==========================================================
	// Controller
	ctrl_state_e state;
	ctrl_state_e next_state;
	logic [DELAY_W-1:0] count;
	logic [DELAY_W-1:0] next_count;
	logic relay;
	logic next_relay;
	logic expired;

	// Delay of zero counts as one cycle so expiry is always seen
	assign expired = (count + 1'b1) >= delay_cycles_i;

	always_comb begin
		next_state = state;
		next_count = count;
		next_relay = relay;
		if (!supply_ok_i) begin
			// Power loss acts as reset for every function
			next_state = ST_IDLE;
			next_count = DELAY_RESET;
			next_relay = RELAY_SHELF;
		end else begin
			unique case (state)
				ST_IDLE: begin
					next_state = ST_ARMED;
					next_count = DELAY_RESET;
				end
				ST_ARMED: begin
					next_count = DELAY_RESET;
					if (trig_close) begin
						unique case (func_sel_i)
							FUNC_SINGLE_SHOT: begin
								next_relay = 1'b1;
								next_state = ST_TIMING;
							end
							FUNC_ON_DELAY: begin
								next_state = ST_TIMING;
							end
							FUNC_MEM_LATCH: begin
								next_relay = !relay;
							end
							default: begin
								next_state = ST_ARMED;
							end
						endcase
					end
				end
				ST_TIMING: begin
					next_count = count + 1'b1;
					if (func_sel_i == FUNC_ON_DELAY && trig_open) begin
						// Early release drops the count
						next_state = ST_ARMED;
						next_count = DELAY_RESET;
					end else if (expired) begin
						next_count = DELAY_RESET;
						if (func_sel_i == FUNC_ON_DELAY) begin
							next_relay = 1'b1;
						end else begin
							next_relay = RELAY_SHELF;
						end
						next_state = ST_DONE;
					end
					// Single shot: trigger edges ignored here
				end
				ST_DONE: begin
					if (func_sel_i == FUNC_ON_DELAY) begin
						if (trig_open) begin
							next_relay = RELAY_SHELF;
							next_state = ST_ARMED;
						end
					end else if (trig_close && !relay) begin
						// Reset by trigger while de-energised
						next_state = ST_ARMED;
					end
				end
				default: begin
					next_state = ST_IDLE;
					next_count = DELAY_RESET;
					next_relay = RELAY_SHELF;
				end
			endcase
		end
	end

	// Clock enable freezes everything, count included
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
			count <= DELAY_RESET;
			relay <= RELAY_SHELF;
		end else if (clk_en_i) begin
			state <= next_state;
			count <= next_count;
			relay <= next_relay;
		end
	end

	assign relay_o = relay;
	assign timing_o = (state == ST_TIMING);

	// ==========================================================
	// Checks
	sequence ss_fire;
		clk_en_i && supply_ok_i && state == ST_ARMED && trig_close &&
			func_sel_i == FUNC_SINGLE_SHOT;
	endsequence

	chk_shot_fires: assert property (@(posedge core_clk_i)
		disable iff (srst_i) ss_fire |=> relay_o && timing_o)
		else $error("single shot did not energise");

	chk_arm_quiet: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && supply_ok_i && state == ST_IDLE |=> $stable(relay_o))
		else $error("arming changed output");

	chk_shot_ignore: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && supply_ok_i && state == ST_TIMING && !expired &&
		func_sel_i == FUNC_SINGLE_SHOT |=> timing_o && relay_o &&
		count == $past(count) + 1'b1)
		else $error("single shot disturbed by trigger");

	// After a shot only a closure or a supply loss may leave the finished state
	chk_shot_rearm: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && supply_ok_i && state == ST_DONE && !trig_close &&
		func_sel_i == FUNC_SINGLE_SHOT |=> state == ST_DONE && !relay_o)
		else $error("rearm without trigger");

	// The shot ends at expiry or on supply loss and at no other time
	chk_shot_expire: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && supply_ok_i && state == ST_TIMING && expired &&
		func_sel_i == FUNC_SINGLE_SHOT |=> !relay_o && !timing_o)
		else $error("single shot did not end at expiry");

	// Expiry with the switch still closed; an open wins over expiry
	sequence od_expiry;
		clk_en_i && supply_ok_i && state == ST_TIMING && expired &&
			!trig_open && func_sel_i == FUNC_ON_DELAY;
	endsequence

	chk_ondly_expire: assert property (@(posedge core_clk_i)
		disable iff (srst_i) od_expiry |=> relay_o && !timing_o)
		else $error("on delay did not transfer at expiry");

	chk_ondly_hold: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && supply_ok_i && state == ST_DONE && !trig_open &&
		func_sel_i == FUNC_ON_DELAY |=> relay_o)
		else $error("on delay dropped while closed");

	// A low enable must hold the count too, or the delay would shrink
	chk_enable_freeze: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		!clk_en_i |=> $stable(state) && $stable(count) && $stable(relay_o))
		else $error("state moved while enable low");

	chk_ondly_shelf: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && supply_ok_i && state == ST_ARMED && trig_close &&
		func_sel_i == FUNC_ON_DELAY |=> timing_o && !relay_o)
		else $error("on delay started wrongly");

	chk_ondly_release: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && supply_ok_i && state == ST_DONE && trig_open &&
		func_sel_i == FUNC_ON_DELAY |=> !relay_o)
		else $error("on delay held after open");

	chk_power_loss: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && !supply_ok_i |=> !relay_o && state == ST_IDLE)
		else $error("supply loss left output energised");

	chk_latch_toggle: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && supply_ok_i && state == ST_ARMED && trig_close &&
		func_sel_i == FUNC_MEM_LATCH |=> relay_o != $past(relay_o))
		else $error("latch did not toggle");

	chk_ondly_abort: assert property (@(posedge core_clk_i)
		disable iff (srst_i)
		clk_en_i && supply_ok_i && state == ST_TIMING && trig_open &&
		func_sel_i == FUNC_ON_DELAY |=> !relay_o && state == ST_ARMED)
		else $error("early open not abandoned");

endmodule

/* File: hw/relay_timing_pkg.sv */
package relay_timing_pkg;

	// ==========================================================
	// Function select codes
	localparam logic [1:0] FUNC_SINGLE_SHOT = 2'h0;
	localparam logic [1:0] FUNC_ON_DELAY = 2'h1;
	localparam logic [1:0] FUNC_MEM_LATCH = 2'h2;

	// ==========================================================
	// Widths and timing
	localparam int DELAY_W = 32;
	localparam int CORE_CLK_MHZ = 100;
	localparam int DEBOUNCE_US = 10;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CORE_CLK_MHZ;
	localparam int DEB_CNT_W = 12;
	localparam logic [DEB_CNT_W-1:0] DEB_LIMIT =
		DEB_CNT_W'(DEBOUNCE_CYCLES - 1);

	// ==========================================================
	// Reset values
	localparam logic [DELAY_W-1:0] DELAY_RESET = 32'h0000_0000;
	localparam logic RELAY_SHELF = 1'b0;

	// ==========================================================
	// Controller states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ARMED = 4'h2,
		ST_TIMING = 4'h4,
		ST_DONE = 4'h8
	} ctrl_state_e;

endpackage

/* File: hw/switch_debounce.sv */
module switch_debounce
	import relay_timing_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic clk_en_i,
	input wire logic raw_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);

	// ==========================================================
	// Synchroniser and stability filter
	logic sync_a;
	logic sync_b;
	logic stable;
	logic [DEB_CNT_W-1:0] cnt;
	logic next_stable;
	logic [DEB_CNT_W-1:0] next_cnt;

	// Count while the synced level differs from the accepted one
	always_comb begin
		next_stable = stable;
		next_cnt = '0;
		if (sync_b != stable) begin
			if (cnt == DEB_LIMIT) begin
				next_stable = sync_b;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	// First stage feeds only the second: metastability guard
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			stable <= 1'b0;
			cnt <= '0;
		end else if (clk_en_i) begin
			sync_a <= raw_i;
			sync_b <= sync_a;
			stable <= next_stable;
			cnt <= next_cnt;
		end
	end

	// One pulse per accepted change, so a bouncing closure counts once
	assign level_o = stable;
	assign rise_o = clk_en_i && !stable && next_stable;
	assign fall_o = clk_en_i && stable && !next_stable;

	chk_single_edge: assert property (@(posedge core_clk_i)
		disable iff (srst_i) rise_o |=> !rise_o)
		else $error("closure edge repeated");

endmodule

/* File: sim/trigger_switch_model.sv */
// ==========================================================
// Dry-contact trigger switch with contact bounce
module trigger_switch_model (
	input wire logic core_clk_i,
	input wire logic close_i,
	output logic contact_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Chatters five times before settling, so one press is one event
	initial begin
		contact_o = 1'b0;
		forever begin
			@(close_i);
			repeat (5) begin
				repeat (7) @(posedge core_clk_i);
				#1 contact_o = ~contact_o;
			end
			// Settle one gap later, never two drives in one step
			repeat (7) @(posedge core_clk_i);
			#1 contact_o = close_i;
		end
	end
endmodule

/* File: sim/test_relay_timing.sv */
// ==========================================================
// Self-checking bench for the trigger timing functions
module test_relay_timing;
	import relay_timing_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int D = 3000;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic clk_en_i = 1'b1;
	logic supply_ok_i = 1'b1;
	logic close = 1'b0;
	logic trigger_sw_i;
	logic [1:0] func_sel_i = FUNC_SINGLE_SHOT;
	logic [DELAY_W-1:0] delay_cycles_i = DELAY_W'(D);
	logic relay_o;
	logic timing_o;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	int n;

	relay_timing i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.clk_en_i(clk_en_i), .supply_ok_i(supply_ok_i),
		.trigger_sw_i(trigger_sw_i), .func_sel_i(func_sel_i),
		.delay_cycles_i(delay_cycles_i), .relay_o(relay_o),
		.timing_o(timing_o));
	trigger_switch_model i_sw (.core_clk_i(core_clk_i), .close_i(close),
		.contact_o(trigger_sw_i));

	initial begin
		forever #5 core_clk_i = ~core_clk_i;
	end

	// Hang guard, well above the roughly 40k cycles needed
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask

	// Sample after the edge settles; gives up after 5000 cycles
	task automatic wait_sig(input bit tim, input logic v, output int k);
		k = 0;
		while (((tim ? timing_o : relay_o) !== v) && k < 5000) begin
			@(posedge core_clk_i);
			#1;
			k++;
		end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic do_reset(input logic [1:0] f);
		close = 1'b0;
		tick(1200);
		func_sel_i = f;
		srst_i = 1'b1;
		tick(3);
		srst_i = 1'b0;
		tick(2);
	endtask

	task automatic single_shot();
		do_reset(FUNC_SINGLE_SHOT);
		tick(20);
		chk({relay_o, timing_o}, 2'h0);
		close = 1'b1;
		wait_sig(0, 1'b1, n);
		chk({relay_o, timing_o}, 2'h3);
		// Open and close again while the shot runs
		fork
			begin
				tick(600);
				close = 1'b0;
				tick(1200);
				close = 1'b1;
			end
			wait_sig(0, 1'b0, n);
		join
		chk(n, D);
		close = 1'b0;
		tick(1200);
		close = 1'b1;
		tick(1200);
		chk(relay_o, 1'b0);
		close = 1'b0;
		tick(1200);
		close = 1'b1;
		wait_sig(0, 1'b1, n);
		chk(relay_o, 1'b1);
		wait_sig(0, 1'b0, n);
	endtask

	task automatic on_delay();
		do_reset(FUNC_ON_DELAY);
		close = 1'b1;
		wait_sig(1, 1'b1, n);
		chk(relay_o, 1'b0);
		wait_sig(1, 1'b0, n);
		chk(n, D);
		chk(relay_o, 1'b1);
		tick(500);
		chk(relay_o, 1'b1);
		close = 1'b0;
		wait_sig(0, 1'b0, n);
		chk(n < 5000, 1'b1);
		tick(1200);
		close = 1'b1;
		wait_sig(1, 1'b1, n);
		close = 1'b0;
		wait_sig(1, 1'b0, n);
		chk(n < D, 1'b1);
		tick(D);
		chk({relay_o, timing_o}, 2'h0);
	endtask

	task automatic mem_latch();
		do_reset(FUNC_MEM_LATCH);
		close = 1'b1;
		wait_sig(0, 1'b1, n);
		chk(relay_o, 1'b1);
		close = 1'b0;
		tick(1200);
		chk(relay_o, 1'b1);
		close = 1'b1;
		wait_sig(0, 1'b0, n);
		chk(n < 5000, 1'b1);
		close = 1'b0;
		tick(1200);
		close = 1'b1;
		wait_sig(0, 1'b1, n);
		supply_ok_i = 1'b0;
		tick(2);
		chk(relay_o, 1'b0);
		supply_ok_i = 1'b1;
		tick(5);
		chk(relay_o, 1'b0);
	endtask

	// Enable low in mid-count stretches the delay by the frozen cycles
	task automatic clock_hold();
		do_reset(FUNC_ON_DELAY);
		close = 1'b1;
		wait_sig(1, 1'b1, n);
		tick(D - 10);
		clk_en_i = 1'b0;
		tick(50);
		chk({relay_o, timing_o}, 2'h1);
		clk_en_i = 1'b1;
		wait_sig(1, 1'b0, n);
		chk(n, 10);
		chk(relay_o, 1'b1);
	endtask

	// Unused function code: closures leave the output alone
	task automatic unused_code();
		do_reset(2'h3);
		close = 1'b1;
		tick(1200);
		chk({relay_o, timing_o}, 2'h0);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		tick(2);
		srst_i = 1'b0;
		single_shot();
		on_delay();
		mem_latch();
		clock_hold();
		unused_code();
		complete_run();
	end
endmodule
